// ### include/mebp_map.svh
// Constants for the memory and expansion bus port: offsets, widths, resets and timings.
`ifndef MEBP_MAP_SVH
`define MEBP_MAP_SVH

`define MEBP_CLK_PERIOD_NS 100
`define MEBP_CYC_MIN(ns) (((ns) + `MEBP_CLK_PERIOD_NS - 1) / `MEBP_CLK_PERIOD_NS)

`define MEBP_RAS_TO_CAS_NS 150
`define MEBP_CAS_PULSE_NS 150
`define MEBP_PRECHARGE_NS 200
`define MEBP_EXP_ACCESS_NS 300

`define MEBP_RAS_TO_CAS_CYC `MEBP_CYC_MIN(`MEBP_RAS_TO_CAS_NS)
`define MEBP_CAS_PULSE_CYC `MEBP_CYC_MIN(`MEBP_CAS_PULSE_NS)
`define MEBP_PRECHARGE_CYC `MEBP_CYC_MIN(`MEBP_PRECHARGE_NS)
`define MEBP_EXP_ACCESS_CYC `MEBP_CYC_MIN(`MEBP_EXP_ACCESS_NS)

`define MEBP_ADDR_W 28
`define MEBP_DATA_W 32
`define MEBP_LANES 4
`define MEBP_LOW_ADDR_W 15
`define MEBP_DRA_W 13
`define MEBP_DRA_LSB 15
`define MEBP_ROW_LSB 13
`define MEBP_WORD_LSB 2

`define MEBP_STROBES_IDLE_N 4'hF
`define MEBP_STROBES_IDLE_H 4'h0
`define MEBP_ALL_LANES 4'hF

`endif

// ### include/mebp_pkg.sv
// Types shared by the memory and expansion bus port modules.
package mebp_pkg;
  typedef enum logic [2:0] {
    MEBP_IDLE = 3'b000,
    MEBP_ROW = 3'b001,
    MEBP_COL = 3'b010,
    MEBP_EXP_SETUP = 3'b011,
    MEBP_EXP_STROBE = 3'b100,
    MEBP_RECOVER = 3'b101
  } mebp_state_type;
  typedef logic [31:0] mebp_word_type;
endpackage

// ### include/mebp_stream_if.sv
// Valid/ready word stream between the port engine and its read buffer.
`timescale 1ns/1ps
`default_nettype none
interface mebp_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### core/mebp_pair_buffer.sv
// Two-entry buffer holding read words until the CPU side accepts them.
`timescale 1ns/1ps
`default_nettype none
module mebp_pair_buffer #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  mebp_stream_if.snk inPort,
  mebp_stream_if.src outPort
);
  logic [W-1:0] slot_r [2];
  logic wrPtr_r;
  logic rdPtr_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  wire push = inPort.valid && inPort.ready;
  wire pop = outPort.valid && outPort.ready;

  assign inPort.ready = (count_r != 2'h2);
  assign outPort.valid = (count_r != 2'h0);
  assign outPort.data = slot_r[rdPtr_r];
  assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else if (clockEnable) begin
      if (push) begin
        slot_r[wrPtr_r] <= inPort.data;
        wrPtr_r <= ~wrPtr_r;
      end
      if (pop) rdPtr_r <= ~rdPtr_r;
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// ### core/mebp_exp_clock.sv
// Gated copy of the core clock for expansion devices.
`timescale 1ns/1ps
`default_nettype none
module mebp_exp_clock (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic freeRun,
  input wire logic cycleActive,
  output logic expClock
);
  logic gateOpen_r;
  wire gateOpen_nxt = clockEnable && (freeRun || cycleActive);

  // The enable changes only while the clock is low, so the gated output never
  // shows a shortened high phase and keeps the core clock's phase.
  always_ff @(negedge clock) begin
    if (reset) gateOpen_r <= 1'b0;
    else gateOpen_r <= gateOpen_nxt;
  end

  assign expClock = clock && gateOpen_r;
endmodule
`default_nettype wire

// ### core/mebp_port.sv
// Memory and expansion bus port: CPU request side to DRAM, ROM and expansion pins.
`timescale 1ns/1ps
`default_nettype none
`include "mebp_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - One shared 32-bit two-way data bus serves DRAM, ROM and expansion.
// - ROM and expansion cycles put byte address bits 0 to 14 out low.
// - Upper address pins carry 13-bit DRAM word address, else byte bits.
// - Four active-low row strobes, one per DRAM bank zero to three.
// - Four active-low column strobes, one per byte lane of the word.
// - One shared active-low output enable while outside parts drive reads.
// - One shared active-low write enable during write transfers.
// - Active-low selects for expansion channels zero to three.
// - Active-high selects for expansion channels four to seven.
// - Ready input low stretches the current expansion cycle.
// - Direction output low on reads, high on writes.
// - Width output high for word cycles, low for byte cycles.
// - Expansion clock has the core clock's frequency and phase.
// - Expansion clock either runs freely or only during expansion cycles.
module mebp_port
  import mebp_pkg::*;
#(
  parameter int EXP_ACCESS_CYC = `MEBP_EXP_ACCESS_CYC,
  parameter int RAS_TO_CAS_CYC = `MEBP_RAS_TO_CAS_CYC,
  parameter int CAS_PULSE_CYC = `MEBP_CAS_PULSE_CYC,
  parameter int PRECHARGE_CYC = `MEBP_PRECHARGE_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqWord,
  input wire logic reqDram,
  input wire logic [2:0] reqSelect,
  input wire logic [`MEBP_ADDR_W-1:0] reqAddr,
  input wire logic [`MEBP_DATA_W-1:0] reqWdata,
  input wire logic [`MEBP_LANES-1:0] reqByteEn,
  output logic rspValid,
  input wire logic rspReady,
  output logic [`MEBP_DATA_W-1:0] rspData,
  input wire logic expClockFreeRun,
  output logic [`MEBP_ADDR_W-1:0] memAddress,
  input wire logic [`MEBP_DATA_W-1:0] memDataIn,
  output logic [`MEBP_DATA_W-1:0] memDataOut,
  output logic memDataOe,
  output logic [3:0] bank_row_strobe_n,
  output logic [`MEBP_LANES-1:0] lane_column_strobe_n,
  output logic shared_output_enable_n,
  output logic shared_write_enable_n,
  output logic [3:0] expansion_select_low,
  output logic [3:0] expansionSelectHigh,
  input wire logic expansion_ready_in,
  output logic transferWrite,
  output logic accessWord,
  output logic expansion_bus_clock
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // The row and column words leave on the upper pins in reverse bit order.
  function automatic logic [`MEBP_DRA_W-1:0] draReverse(
    input logic [`MEBP_DRA_W-1:0] part
  );
    logic [`MEBP_DRA_W-1:0] flipped;
    flipped = '0;
    for (int i = 0; i < `MEBP_DRA_W; i++) begin
      flipped[i] = part[`MEBP_DRA_W-1-i];
    end
    return flipped;
  endfunction

  function automatic logic [`MEBP_LANES-1:0] laneMask(
    input logic isWord,
    input logic isWrite,
    input logic [`MEBP_LANES-1:0] byteEn,
    input logic [1:0] lane
  );
    logic [`MEBP_LANES-1:0] mask;
    mask = `MEBP_ALL_LANES;
    if (!isWord) mask = 4'h1 << lane;
    else if (isWrite) mask = byteEn;
    return mask;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Request latch and sequencer state.

  mebp_state_type state_r;
  mebp_state_type state_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic write_r;
  logic word_r;
  logic dram_r;
  logic [2:0] select_r;
  logic [`MEBP_ADDR_W-1:0] addr_r;
  logic [`MEBP_DATA_W-1:0] wdata_r;
  logic [`MEBP_LANES-1:0] byteEn_r;

  mebp_stream_if #(.W(`MEBP_DATA_W)) readIn ();
  mebp_stream_if #(.W(`MEBP_DATA_W)) readOut ();

  // A read starts only when the buffer has room, so a stalled CPU side never
  // forces a word captured from the pins to be dropped.
  wire bufferRoom = readIn.ready;
  wire isIdle = (state_r == MEBP_IDLE);
  assign reqReady = isIdle && clockEnable && (reqWrite || bufferRoom);
  wire take = reqValid && reqReady;

  wire countDone = (count_r == 8'h0);
  wire expCycle = (state_r == MEBP_EXP_SETUP) || (state_r == MEBP_EXP_STROBE);
  wire dramCycle = (state_r == MEBP_ROW) || (state_r == MEBP_COL);
  wire expFinish = (state_r == MEBP_EXP_STROBE) && countDone && expansion_ready_in;
  wire dramFinish = (state_r == MEBP_COL) && countDone;
  wire finish = expFinish || dramFinish;

  wire [7:0] rasCasLoad = 8'(RAS_TO_CAS_CYC - 1);
  wire [7:0] casLoad = 8'(CAS_PULSE_CYC - 1);
  wire [7:0] prechargeLoad = 8'(PRECHARGE_CYC - 1);
  wire [7:0] expLoad = 8'(EXP_ACCESS_CYC - 1);

  always_comb begin
    state_nxt = state_r;
    count_nxt = countDone ? count_r : count_r - 8'h1;
    unique case (state_r)
      MEBP_IDLE: begin
        if (take) begin
          state_nxt = reqDram ? MEBP_ROW : MEBP_EXP_SETUP;
          count_nxt = reqDram ? rasCasLoad : 8'h0;
        end
      end
      MEBP_ROW: begin
        if (countDone) begin
          state_nxt = MEBP_COL;
          count_nxt = casLoad;
        end
      end
      MEBP_COL: begin
        if (countDone) begin
          state_nxt = MEBP_RECOVER;
          count_nxt = prechargeLoad;
        end
      end
      MEBP_EXP_SETUP: begin
        state_nxt = MEBP_EXP_STROBE;
        count_nxt = expLoad;
      end
      MEBP_EXP_STROBE: begin
        // The access time runs out first; then a low ready holds the strobe.
        if (expFinish) begin
          state_nxt = MEBP_RECOVER;
          count_nxt = 8'h0;
        end
      end
      MEBP_RECOVER: begin
        if (countDone) state_nxt = MEBP_IDLE;
      end
      default: begin
        state_nxt = MEBP_IDLE;
        count_nxt = 8'h0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= MEBP_IDLE;
      count_r <= 8'h0;
    end else if (clockEnable) begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      write_r <= 1'b0;
      word_r <= 1'b0;
      dram_r <= 1'b0;
      select_r <= 3'h0;
      addr_r <= '0;
      wdata_r <= '0;
      byteEn_r <= '0;
    end else if (clockEnable && take) begin
      write_r <= reqWrite;
      word_r <= reqWord;
      dram_r <= reqDram;
      select_r <= reqSelect;
      addr_r <= reqAddr;
      wdata_r <= reqWdata;
      byteEn_r <= reqByteEn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address multiplexing.

  wire [25:0] wordAddr = addr_r[`MEBP_ADDR_W-1:`MEBP_WORD_LSB];
  wire [`MEBP_DRA_W-1:0] rowPart = wordAddr[`MEBP_ROW_LSB +: `MEBP_DRA_W];
  wire [`MEBP_DRA_W-1:0] colPart = wordAddr[`MEBP_DRA_W-1:0];
  wire [`MEBP_DRA_W-1:0] draNow = (state_r == MEBP_ROW) ? rowPart : colPart;
  wire [`MEBP_ADDR_W-1:0] dramPins = {draReverse(draNow), `MEBP_LOW_ADDR_W'(0)};

  // Byte address on every pin outside DRAM cycles, low 15 bits included.
  assign memAddress = dramCycle ? dramPins : addr_r;

  //////////////////////////////////////////////////////////////////////////////
  // Strobes and enables; all rest inactive unless a cycle owns them.

  wire [1:0] lane = addr_r[1:0];
  wire [`MEBP_LANES-1:0] lanes = laneMask(word_r, write_r, byteEn_r, lane);
  wire [3:0] bankHot = 4'h1 << select_r[1:0];
  wire [7:0] chanHot = 8'h01 << select_r;
  wire strobePhase = (state_r == MEBP_COL) || (state_r == MEBP_EXP_STROBE);

  assign bank_row_strobe_n = dramCycle ? ~bankHot : `MEBP_STROBES_IDLE_N;
  assign lane_column_strobe_n =
    (state_r == MEBP_COL) ? ~lanes : `MEBP_STROBES_IDLE_N;
  assign expansion_select_low =
    expCycle ? ~chanHot[3:0] : `MEBP_STROBES_IDLE_N;
  assign expansionSelectHigh =
    expCycle ? chanHot[7:4] : `MEBP_STROBES_IDLE_H;
  assign shared_output_enable_n = !(strobePhase && !write_r);
  assign shared_write_enable_n = !(strobePhase && write_r);
  assign transferWrite = !isIdle && write_r;
  assign accessWord = !isIdle && word_r;

  //////////////////////////////////////////////////////////////////////////////
  // Data bus.

  // The pins are driven for a write until its recovery state, and never during reads,
  // so the external part and the port never fight over the lanes.
  assign memDataOe = !isIdle && (state_r != MEBP_RECOVER) && write_r;
  assign memDataOut = wdata_r;

  assign readIn.valid = finish && !write_r && clockEnable;
  assign readIn.data = memDataIn;

  mebp_pair_buffer #(.W(`MEBP_DATA_W)) readBuffer (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .inPort(readIn.snk),
    .outPort(readOut.src)
  );

  assign rspValid = readOut.valid;
  assign rspData = readOut.data;
  assign readOut.ready = rspReady && clockEnable;

  //////////////////////////////////////////////////////////////////////////////
  // Expansion clock.

  mebp_exp_clock expClockGate (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .freeRun(expClockFreeRun),
    .cycleActive(expCycle && !dram_r),
    .expClock(expansion_bus_clock)
  );

endmodule
`default_nettype wire

// ### tb/mebp_port_sva.sv
// Pin-level checks on the memory and expansion bus port.
`timescale 1ns/1ps
`default_nettype none
`include "mebp_map.svh"
module mebp_port_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic reqReady,
  input wire logic [`MEBP_ADDR_W-1:0] memAddress,
  input wire logic memDataOe,
  input wire logic [3:0] bank_row_strobe_n,
  input wire logic [3:0] lane_column_strobe_n,
  input wire logic shared_output_enable_n,
  input wire logic shared_write_enable_n,
  input wire logic [3:0] expansion_select_low,
  input wire logic [3:0] expansionSelectHigh,
  input wire logic expansion_ready_in,
  input wire logic transferWrite
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic anySel = (~&expansion_select_low) | (|expansionSelectHigh);
  wire logic noCas = &lane_column_strobe_n;
  wire logic expStrobe = anySel & ~(shared_write_enable_n & shared_output_enable_n);
  sequence rowOpen;
    $fell(&bank_row_strobe_n);
  endsequence
  sequence colAfterTwo;
    noCas [*2] ##1 !noCas;
  endsequence
  a_idle_quiet: assert property (reqReady |-> bank_row_strobe_n == 4'hF && noCas
    && shared_output_enable_n && shared_write_enable_n && !memDataOe
    && expansion_select_low == 4'hF && expansionSelectHigh == 4'h0) else $error("idle pins");
  a_one_bank: assert property ($onehot0(~bank_row_strobe_n))
    else $error("two banks");
  a_one_select: assert property ($onehot0({~expansion_select_low, expansionSelectHigh}))
    else $error("two selects");
  a_write_dir: assert property (!shared_write_enable_n |-> transferWrite && memDataOe)
    else $error("write dir");
  a_read_dir: assert property (!shared_output_enable_n |-> !transferWrite && !memDataOe)
    else $error("read dir");
  a_cas_under_ras: assert property (!noCas |-> !(&bank_row_strobe_n))
    else $error("lane strobe alone");
  a_dram_low_zero: assert property (!(&bank_row_strobe_n) |-> memAddress[14:0] == 15'h0000)
    else $error("dram low bits");
  a_ready_stretch: assert property (expStrobe && !expansion_ready_in && clockEnable |=> expStrobe)
    else $error("stall ignored");
  a_row_to_col: assert property (disable iff (reset || !clockEnable) rowOpen |-> colAfterTwo)
    else $error("row to column");
endmodule
bind mebp_port mebp_port_sva u_sva (.clock, .reset, .clockEnable, .reqReady, .memAddress,
  .memDataOe, .bank_row_strobe_n, .lane_column_strobe_n, .shared_output_enable_n,
  .shared_write_enable_n, .expansion_select_low, .expansionSelectHigh, .expansion_ready_in,
  .transferWrite);
`default_nettype wire

// ### tb/mebp_mem_model.sv
// Behavioural memory and expansion device on the far side of the port.
`timescale 1ns/1ps
`default_nettype none
module mebp_mem_model (
  input wire logic clock,
  input wire logic [3:0] bank_row_strobe_n,
  input wire logic [3:0] expansion_select_low,
  input wire logic [3:0] expansionSelectHigh,
  input wire logic shared_output_enable_n,
  input wire logic [7:0] stallLen,
  output logic [31:0] memDataIn,
  output logic expansion_ready_in
);
  logic [31:0] lastData = 32'h0;
  logic [7:0] selCount = 8'h00;
  wire logic anySel = (~&expansion_select_low) | (|expansionSelectHigh);
  wire logic [31:0] readWord = {16'h5A00, 4'h0, ~bank_row_strobe_n, ~expansion_select_low,
    expansionSelectHigh};
  // A released bus shows the inverse of the last word, so a late capture cannot pass.
  assign memDataIn = shared_output_enable_n ? ~lastData : readWord;
  assign expansion_ready_in = !(anySel && selCount < stallLen);
  always @(posedge clock) begin
    if (!shared_output_enable_n) lastData <= readWord;
    selCount <= anySel ? selCount + 8'h01 : 8'h00;
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the memory and expansion bus port.
`timescale 1ns/1ps
`default_nettype none
`include "mebp_map.svh"
module tb;
  logic clock, reset, clockEnable, reqValid, reqReady, reqWrite, reqWord, reqDram;
  logic rspValid, rspReady, expClockFreeRun, memDataOe, shared_output_enable_n;
  logic shared_write_enable_n, expansion_ready_in, transferWrite, accessWord;
  logic expansion_bus_clock;
  logic [2:0] reqSelect;
  logic [27:0] reqAddr, memAddress, addrSeen;
  logic [31:0] reqWdata, rspData, memDataIn, memDataOut, wrOut;
  logic [3:0] reqByteEn, bank_row_strobe_n, lane_column_strobe_n, expansion_select_low;
  logic [3:0] expansionSelectHigh, rasSeen, casSeen, flagSeen;
  logic [7:0] selSeen, stallLen, selCycles;
  int fails = 0;
  int nCompared = 0;
  mebp_port dut (.clock, .reset, .clockEnable, .reqValid, .reqReady, .reqWrite, .reqWord,
    .reqDram, .reqSelect, .reqAddr, .reqWdata, .reqByteEn, .rspValid, .rspReady, .rspData,
    .expClockFreeRun, .memAddress, .memDataIn, .memDataOut, .memDataOe, .bank_row_strobe_n,
    .lane_column_strobe_n, .shared_output_enable_n, .shared_write_enable_n,
    .expansion_select_low, .expansionSelectHigh, .expansion_ready_in, .transferWrite,
    .accessWord, .expansion_bus_clock);
  mebp_mem_model model (.clock, .bank_row_strobe_n, .expansion_select_low,
    .expansionSelectHigh, .shared_output_enable_n, .stallLen, .memDataIn,
    .expansion_ready_in);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    rasSeen <= rasSeen | ~bank_row_strobe_n;
    casSeen <= casSeen | ~lane_column_strobe_n;
    selSeen <= selSeen | {expansionSelectHigh, ~expansion_select_low};
    flagSeen <= flagSeen | {!shared_write_enable_n, !shared_output_enable_n, transferWrite,
      accessWord};
    if (!shared_write_enable_n) wrOut <= memDataOut;
    if ((~&expansion_select_low) | (|expansionSelectHigh)) begin
      addrSeen <= memAddress;
      selCycles <= selCycles + 8'h01;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic run(input logic w, input logic wd, input logic d, input logic [2:0] s,
    input logic [27:0] a);
    int n;
    @(negedge clock);
    {rasSeen, casSeen, selSeen, flagSeen, selCycles} = '0;
    {reqValid, reqWrite, reqWord, reqDram, reqSelect, reqAddr} = {1'b1, w, wd, d, s, a};
    for (n = 0; reqReady !== 1'b1 && n < 50; n++) @(negedge clock);
    @(negedge clock);
    reqValid = 1'b0;
    // A write shows ready whenever the port is idle, even with a full read buffer.
    reqWrite = 1'b1;
    for (n = 0; reqReady !== 1'b1 && n < 50; n++) @(negedge clock);
    if (n >= 50) chk(32'h0, 32'h1, "cycle hung");
  endtask
  task automatic get_rsp(input logic [31:0] e);
    int n;
    for (n = 0; rspValid !== 1'b1 && n < 50; n++) @(negedge clock);
    chk(rspData, e, "read word");
    rspReady = 1'b1;
    @(negedge clock);
    rspReady = 1'b0;
  endtask
  task automatic t_dram_read;
    for (int b = 0; b < 4; b++) begin
      run(1'b0, 1'b1, 1'b1, 3'(b), 28'h0123450 + 28'(b * 4));
      chk(32'(rasSeen), 32'(4'h1 << b), "row strobe");
      chk(32'(casSeen), 32'h0000000F, "word lanes");
      chk(32'(flagSeen), 32'h5, "read flags");
      get_rsp(32'h5A000000 | (32'h100 << b));
    end
  endtask
  task automatic t_dram_write;
    for (int l = 0; l < 4; l++) begin
      run(1'b1, 1'b0, 1'b1, 3'h2, 28'h0ABCDE0 + 28'(l));
      chk(32'(casSeen), 32'(4'h1 << l), "byte lane");
      chk(32'(flagSeen), 32'hA, "byte write flags");
      chk(wrOut, reqWdata, "write data");
    end
    reqByteEn = 4'h5;
    run(1'b1, 1'b1, 1'b1, 3'h1, 28'h0ABCDE0);
    chk(32'(casSeen), 32'h5, "masked word");
    reqByteEn = 4'hF;
  endtask
  task automatic t_exp_read;
    for (int c = 0; c < 8; c++) begin
      run(1'b0, 1'b1, 1'b0, 3'(c), 28'h7E54321 + 28'(c));
      chk(32'(selSeen), 32'(8'h01 << c), "channel select");
      chk(32'(addrSeen[14:0]), 32'(reqAddr[14:0]), "low address");
      chk(32'(addrSeen[27:16]), 32'(reqAddr[27:16]), "high address");
      chk(32'(selCycles), 32'h4, "strobe length");
      get_rsp(32'h5A000000 | (32'h1 << ((c + 4) % 8)));
    end
  endtask
  task automatic t_exp_stall;
    stallLen = 8'h06;
    run(1'b1, 1'b1, 1'b0, 3'h5, 28'h0000124);
    chk(32'(selCycles >= 8'h07), 32'h1, "stretched strobe");
    stallLen = 8'h00;
  endtask
  task automatic t_buffer_full;
    run(1'b0, 1'b1, 1'b1, 3'h0, 28'h0000010);
    run(1'b0, 1'b1, 1'b1, 3'h3, 28'h0000020);
    reqWrite = 1'b0;
    reqValid = 1'b1;
    repeat (3) @(negedge clock);
    chk(32'(reqReady), 32'h0, "full buffer refusal");
    reqValid = 1'b0;
    get_rsp(32'h5A000100);
    get_rsp(32'h5A000800);
  endtask
  task automatic t_exp_clock;
    expClockFreeRun = 1'b1;
    repeat (3) @(posedge clock);
    #25 chk(32'(expansion_bus_clock), 32'h1, "free clock high");
    #50 chk(32'(expansion_bus_clock), 32'h0, "free clock low");
    expClockFreeRun = 1'b0;
    repeat (3) @(posedge clock);
    #25 chk(32'(expansion_bus_clock), 32'h0, "gated clock");
    @(negedge clock);
    clockEnable = 1'b0;
    @(negedge clock);
    chk(32'(reqReady), 32'h0, "frozen port");
    clockEnable = 1'b1;
  endtask
  task automatic print_verdict;
    $display("Compared %0d, failed %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    print_verdict();
  end
  initial begin
    {reset, clockEnable, reqValid, reqWrite, reqWord, reqDram, rspReady} = 7'h60;
    {expClockFreeRun, reqSelect, reqAddr, stallLen} = '0;
    {reqWdata, reqByteEn} = {32'hC3A5961E, 4'hF};
    repeat (12) @(negedge clock);
    reset = 1'b0;
    t_dram_read();
    t_dram_write();
    t_exp_read();
    t_exp_stall();
    t_buffer_full();
    t_exp_clock();
    print_verdict();
  end
endmodule
`default_nettype wire
